// ===== core/brd_pkg.sv
// Package for the boot remap memory decoder: address map, variant sizes, types.
// Assumes a 32-bit byte address from the processor bus master.
package brd_pkg;
    localparam logic [31:0] FLASH_BASE   = 32'h0010_0000;
    localparam logic [31:0] SRAM_BASE    = 32'h0020_0000;
    localparam logic [31:0] ROM_BASE     = 32'h0030_0000;
    localparam logic [31:0] ZERO_BASE    = 32'h0000_0000;
    localparam logic [31:0] REGION_SPAN  = 32'h0010_0000;
    localparam logic [31:0] ROM_SIZE     = 32'h0000_8000;
    localparam logic [1:0]  VAR_LARGE    = 2'h0;
    localparam logic [1:0]  VAR_MID      = 2'h1;
    localparam logic [1:0]  VAR_SMALL    = 2'h2;
    localparam logic [31:0] SRAM_128K    = 32'h0002_0000;
    localparam logic [31:0] SRAM_64K     = 32'h0001_0000;
    localparam logic [31:0] SRAM_32K     = 32'h0000_8000;
    localparam logic [31:0] FLASH_512K   = 32'h0008_0000;
    localparam logic [31:0] FLASH_256K   = 32'h0004_0000;
    localparam logic [31:0] FLASH_128K   = 32'h0002_0000;
    localparam logic        BOOT_SEL_RST = 1'b0;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } brd_req_t;

    typedef struct packed {
        logic        sram;
        logic        rom;
        logic        flash;
        logic        none;
        logic [31:0] offset;
    } brd_sel_t;
endpackage

// ===== core/brd_decoder.sv
// Boot remap memory decoder: routes processor accesses to SRAM, ROM or Flash.
// Assumes one clock; requests are sampled each cycle and decoded a cycle later.
// What this block does
// - Before remap, SRAM answers only at its fixed base, never at zero.
// - After remap, SRAM answers at zero and still at its fixed base.
// - ROM always answers at its fixed base, whatever remap or boot select.
// - Flash always answers at its fixed base, whatever remap or boot select.
// - Before remap with boot-select bit 2 set, Flash also answers at zero.
// - Boot-select clear boots from ROM; set boots from Flash.
// - Boot-select changes only through flash controller clear-bit and set-bit commands, the erase input and system reset.
// - Erase input clears boot-select bit 2 so the next boot uses ROM.
// - Decoded SRAM size follows the variant: 128, 64 or 32 kilobytes.
// - Decoded Flash size follows variant: one window of 512K, 256K or 128K.
`timescale 1ns/100ps
module brd_decoder #(
    parameter logic [1:0] VARIANT = brd_pkg::VAR_LARGE
) (
    input  wire logic              ref_clk_i,
    input  wire logic              reset_i,
    input  wire brd_pkg::brd_req_t req_i,
    input  wire logic              remap_cmd_i,
    input  wire logic              nv_set_cmd_i,
    input  wire logic              nv_clr_cmd_i,
    input  wire logic              erase_i,
    output brd_pkg::brd_sel_t      sel_o,
    output logic                   remapped_o,
    output logic                   boot_select_nv_bit_o
);
    function automatic logic in_win(input logic [31:0] a, input logic [31:0] base,
                                    input logic [31:0] size);
        in_win = (a >= base) && ((a - base) < size);
    endfunction

    // Sizes fixed by variant
    localparam logic [31:0] SRAM_SZ = (VARIANT == brd_pkg::VAR_LARGE) ? brd_pkg::SRAM_128K :
                                      (VARIANT == brd_pkg::VAR_MID)   ? brd_pkg::SRAM_64K :
                                                                        brd_pkg::SRAM_32K;
    localparam logic [31:0] FLASH_SZ = (VARIANT == brd_pkg::VAR_LARGE) ? brd_pkg::FLASH_512K :
                                       (VARIANT == brd_pkg::VAR_MID)   ? brd_pkg::FLASH_256K :
                                                                         brd_pkg::FLASH_128K;

    logic              remap_r;
    logic              remap_nxt;
    logic              nv_r;
    logic              nv_nxt;
    brd_pkg::brd_sel_t sel_r;
    brd_pkg::brd_sel_t sel_nxt;

    // The real bit is non-volatile; here it only survives while power stays, so a
    // system reset returns it to the default. Erase outranks a same-cycle set.
    always_comb begin
        remap_nxt = remap_r | remap_cmd_i;
        nv_nxt    = nv_r;
        if (nv_set_cmd_i) begin
            nv_nxt = 1'b1;
        end
        if (nv_clr_cmd_i || erase_i) begin
            nv_nxt = 1'b0;
        end
    end

    always_comb begin
        logic [31:0] a;
        a = req_i.addr;
        sel_nxt = '0;
        if (!req_i.valid) begin
            sel_nxt = '0;
        end else if (in_win(a, brd_pkg::ZERO_BASE, brd_pkg::REGION_SPAN)) begin
            if (remap_r) begin
                sel_nxt.sram   = in_win(a, brd_pkg::ZERO_BASE, SRAM_SZ);
                sel_nxt.offset = a;
            end else if (nv_r) begin
                sel_nxt.flash  = in_win(a, brd_pkg::ZERO_BASE, FLASH_SZ);
                sel_nxt.offset = a;
            end else begin
                sel_nxt.rom    = in_win(a, brd_pkg::ZERO_BASE, brd_pkg::ROM_SIZE);
                sel_nxt.offset = a;
            end
            sel_nxt.none = ~(sel_nxt.sram | sel_nxt.flash | sel_nxt.rom);
        end else if (in_win(a, brd_pkg::FLASH_BASE, FLASH_SZ)) begin
            sel_nxt.flash  = 1'b1;
            sel_nxt.offset = a - brd_pkg::FLASH_BASE;
        end else if (in_win(a, brd_pkg::SRAM_BASE, SRAM_SZ)) begin
            sel_nxt.sram   = 1'b1;
            sel_nxt.offset = a - brd_pkg::SRAM_BASE;
        end else if (in_win(a, brd_pkg::ROM_BASE, brd_pkg::ROM_SIZE)) begin
            sel_nxt.rom    = 1'b1;
            sel_nxt.offset = a - brd_pkg::ROM_BASE;
        end else begin
            sel_nxt.none = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            remap_r <= 1'b0;
            nv_r    <= brd_pkg::BOOT_SEL_RST;
            sel_r   <= '0;
        end else begin
            remap_r <= remap_nxt;
            nv_r    <= nv_nxt;
            sel_r   <= sel_nxt;
        end
    end

    assign sel_o                = sel_r;
    assign remapped_o           = remap_r;
    assign boot_select_nv_bit_o = nv_r;
endmodule

// ===== dv/brd_cpu.sv
// Bus master model: presents each issued access on the request port.
// Assumes the bench issues at most one address a cycle.
`timescale 1ns/100ps
module brd_cpu (
    input  wire logic         ref_clk_i,
    input  wire logic         go_i,
    input  wire logic [31:0]  addr_i,
    output brd_pkg::brd_req_t req_o
);
    // Idle cycles carry an inverted address, never a stale one
    always_ff @(posedge ref_clk_i) req_o <= '{go_i, go_i ? addr_i : ~addr_i};
endmodule

// ===== dv/brd_chk_sva.sv
// Checker: decoder routing and flag history at the ports.
// Assumes the large variant.
`timescale 1ns/100ps
module brd_chk (
    input wire logic              ref_clk_i, reset_i, remap_cmd_i, erase_i, nv_clr_cmd_i,
    input wire brd_pkg::brd_req_t req_i,
    input wire brd_pkg::brd_sel_t sel_o,
    input wire logic              remapped_o, boot_select_nv_bit_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_zero; req_i.valid && req_i.addr[31:15] == 17'h0; endsequence
    property p_rom; req_i.valid && req_i.addr[31:15] == 17'h60 |=> sel_o.rom; endproperty
    a_rom: assert property (p_rom) else $error("rom base");
    property p_fla; req_i.valid && req_i.addr[31:17] == 15'h8 |=> sel_o.flash; endproperty
    a_fla: assert property (p_fla) else $error("flash base");
    property p_nsr; !remapped_o ##0 s_zero |=> !sel_o.sram; endproperty
    a_nsr: assert property (p_nsr) else $error("early sram");
    property p_rsr; remapped_o ##0 s_zero |=> sel_o.sram; endproperty
    a_rsr: assert property (p_rsr) else $error("no sram");
    property p_fz; !remapped_o && boot_select_nv_bit_o ##0 s_zero |=> sel_o.flash; endproperty
    a_fz: assert property (p_fz) else $error("no flash");
    property p_rz; !remapped_o && !boot_select_nv_bit_o ##0 s_zero |=> sel_o.rom; endproperty
    a_rz: assert property (p_rz) else $error("no rom");
    property p_stk; remap_cmd_i || remapped_o |=> remapped_o; endproperty
    a_stk: assert property (p_stk) else $error("remap lost");
    property p_ers; erase_i || nv_clr_cmd_i |=> !boot_select_nv_bit_o; endproperty
    a_ers: assert property (p_ers) else $error("bit kept");
endmodule
bind brd_decoder brd_chk u_chk (.ref_clk_i, .reset_i, .remap_cmd_i, .erase_i, .nv_clr_cmd_i,
    .req_i, .sel_o, .remapped_o, .boot_select_nv_bit_o);

// ===== dv/testbench.sv
// Bench: random and boundary accesses before remap with boot select clear and set, and after remap with it set.
// Assumes the large variant and the bus master model.
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
    logic ref_clk_i = 0, reset_i = 1, go = 0, rm = 0, bt = 0, rmo, bto;
    logic [3:0] cm = 0;
    logic [31:0] ad = 0, b[8] = '{'h7FFC, 'h8000, 'h1FFFC, 'h20000, 'h7FFFC, 'h80000, 'h21FFFC, 'h400000};
    logic [15:0] lf = 16'hF9EA;
    logic [23:0] q[$], e;
    int fail_count = 0, compares = 0, cyc = 0, m[4] = '{0, 2, 0, 1}, s[12] = '{9, 1, 9, 3, 9, 1, 2, 9, 1, 0, 9, 4};
    brd_pkg::brd_req_t req;
    brd_pkg::brd_sel_t sel;
    always #4 ref_clk_i = ~ref_clk_i;
    brd_cpu cpu (.ref_clk_i, .go_i(go), .addr_i(ad), .req_o(req));
    brd_decoder uut (.ref_clk_i, .reset_i, .req_i(req), .remap_cmd_i(cm[0]), .nv_set_cmd_i(cm[1]),
        .nv_clr_cmd_i(cm[2]), .erase_i(cm[3]), .sel_o(sel), .remapped_o(rmo),
        .boot_select_nv_bit_o(bto));
    function automatic logic [23:0] ex(logic [31:0] a);
        int r, sz[3] = '{'h20000, 'h8000, 'h80000};
        r = a[31:22] != 0 ? 3 : a[21:20] == 0 ? (rm ? 0 : bt ? 2 : 1) : m[a[21:20]];
        return (r < 3 && a[19:0] < sz[r]) ? {4'h8 >> r, a[19:0]} : {4'h1, a[19:0]};
    endfunction
    function automatic logic [15:0] nx(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic acc(input logic [31:0] a);
        go <= 1;
        ad <= a;
        q.push_back(ex(a));
        @(posedge ref_clk_i);
    endtask
    task automatic run;
        for (int i = 0; i < 60; i++) begin
            lf = nx(lf);
            acc({10'h0, lf[1:0], lf[15:2], 6'h0});
        end
        foreach (b[i]) acc(b[i]);
        go <= 0;
        repeat (3) @(posedge ref_clk_i);
    endtask
    task automatic cmd(input int k);
        cm[k] <= 1;
        @(posedge ref_clk_i);
        cm <= 0;
        rm |= k == 0;
        bt = k ? k == 1 : bt;
        repeat (3) @(posedge ref_clk_i);
        `CHK("remap", rm, rmo)
        `CHK("boot", bt, bto)
    endtask
    task automatic rst;
        reset_i <= 1;
        rm = 0;
        bt = 0;
        repeat (4) @(posedge ref_clk_i);
        reset_i <= 0;
    endtask
    task automatic stop_test;
        if (fail_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Compare on the falling edge so registered outputs have settled
    always @(negedge ref_clk_i) if (|sel[35:32]) begin
        e = q.size() ? q.pop_front() : 24'hx;
        `CHK("sel", e[23:20], sel[35:32])
        if (!sel.none) `CHK("off", {12'h0, e[19:0]}, sel.offset)
    end
    always @(posedge ref_clk_i) if (++cyc == 20000) begin
        fail_count++;
        stop_test;
    end
    initial begin
        @(posedge ref_clk_i);
        rst;
        // Sequence: 9 runs traffic, 4 resets, else one command
        foreach (s[i]) if (s[i] == 9) run; else if (s[i] == 4) rst; else cmd(s[i]);
        run;
        stop_test;
    end
endmodule
